// File: pmr_consts.svh
`ifndef PMR_CONSTS_SVH
`define PMR_CONSTS_SVH

// ==========================================================================
// register word addresses on the register port
`define PMR_ADDR_SHUNT    8'h01
`define PMR_ADDR_BUS      8'h02
`define PMR_ADDR_POWER    8'h03
`define PMR_ADDR_CURRENT  8'h04
`define PMR_ADDR_CALIB    8'h05

// ==========================================================================
// field positions of the bus voltage word
`define PMR_OVF_BIT       0
`define PMR_CONVERSION_READY_FLAG_BIT      1
`define PMR_BUS_MAG_LSB   3

// ==========================================================================
// reset values
`define PMR_RESULT_RST    16'h0000
`define PMR_CALIB_RST     16'h0000

// ==========================================================================
// full-scale codes
`define PMR_SHUNT_FS_G1   16'h0FA0
`define PMR_BUS_FS_16V    13'h0FA0
`define PMR_BUS_FS_32V    13'h1F40

// ==========================================================================
// arithmetic constants and operating mode codes
`define PMR_CUR_SHIFT     12
`define PMR_PWR_DIV       30'h0001388
`define PMR_MODE_PDOWN    3'h0
`define PMR_MODE_DISABLE  3'h4
`define PMR_MATH_LAT      2

`endif

// File: pmr_pkg.sv
`default_nettype none

package pmr_pkg;

  // one register port request from the serial engine
  typedef struct packed {
    logic [7:0]  addr;
    logic        rd;
    logic        wr;
    logic [15:0] wdata;
  } pmr_reg_req_t;

  // result of the current and power arithmetic
  typedef struct packed {
    logic [15:0] current;
    logic [15:0] power;
    logic        ovf;
  } pmr_math_t;

  // conversion sequencer
  typedef enum logic [1:0] {
    PMR_IDLE = 2'b01,
    PMR_CALC = 2'b10
  } pmr_state_t;

endpackage

`default_nettype wire

// File: pmr_math.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmr_consts.svh"

module pmr_math
  import pmr_pkg::*;
(
  input  wire logic        mclk,     // system clock
  input  wire logic        rst,      // async reset, active high
  input  wire logic        start,    // one-cycle start pulse
  input  wire logic [15:0] shunt,    // clipped shunt code, signed
  input  wire logic [15:0] cal,      // calibration word, bit 0 zero
  input  wire logic [12:0] bus_cnt,  // right-aligned bus count
  output logic             done,     // one-cycle pulse, results valid
  output pmr_math_t        res       // current, power, overflow
);

  // ========================================================================
  // stage 1: current = shunt * cal / 4096
  logic signed [32:0] prod_w;
  logic signed [32:0] cur_full_w;
  logic               cur_ovf_w;
  logic [15:0]        cur1_r;
  logic               ovf1_r;
  logic [12:0]        bus1_r;
  logic               v1_r;

  assign prod_w     = $signed(shunt) * $signed({1'b0, cal});
  assign cur_full_w = prod_w >>> `PMR_CUR_SHIFT;
  assign cur_ovf_w  = (cur_full_w > 33'sh7FFF) || (cur_full_w < -33'sh8000);

  // saturate so an overflowed result stays at the end of the range
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      cur1_r <= 16'h0000;
      ovf1_r <= 1'b0;
      bus1_r <= 13'h0000;
      v1_r   <= 1'b0;
    end else begin
      v1_r <= start;
      if (start) begin
        ovf1_r <= cur_ovf_w;
        bus1_r <= bus_cnt;
        if (!cur_ovf_w)
          cur1_r <= cur_full_w[15:0];
        else
          cur1_r <= cur_full_w[32] ? 16'h8000 : 16'h7FFF;
      end
    end
  end

  // ========================================================================
  // stage 2: power = |current| * bus / 5000
  logic [16:0] mag_w;
  logic [29:0] prod2_w;
  logic [29:0] quot_w;

  assign mag_w   = cur1_r[15] ? (17'h00000 - {cur1_r[15], cur1_r}) : {1'b0, cur1_r};
  assign prod2_w = mag_w * bus1_r;
  assign quot_w  = prod2_w / `PMR_PWR_DIV;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      res  <= '0;
      done <= 1'b0;
    end else begin
      done <= v1_r;
      if (v1_r) begin
        res.current <= cur1_r;
        res.power   <= (|quot_w[29:16]) ? 16'hFFFF : quot_w[15:0];
        res.ovf     <= ovf1_r || (|quot_w[29:16]);
      end
    end
  end

  // ========================================================================
  // checks
  math_latency_a: assert property (@(posedge mclk) disable iff (rst)
    start |-> ##2 done) else $error("math result not ready two cycles after start");

endmodule
`default_nettype wire

// File: pmr_top.sv
`timescale 1ns/1ps
`default_nettype none
`include "pmr_consts.svh"

// Behaviour
// - Shunt reading beyond gain full scale saturates at the full-scale code.
// - Bus word: magnitude in 15..3 at 4 mV, bit 1 ready, bit 0 overflow.
// - Range select one: bus magnitude spans 32 V, count 8000.
// - Range select zero: full scale 16 V, count 4000, bit 15 reads zero.
// - Ready flag sets only after all arithmetic; results readable at any time.
// - Writing an operating mode clears ready, except power-down or disable.
// - Reading the power word clears ready; a poller reads power last.
// - Overflow flag sets when current or power computation exceeds its range.
// - Power word is current times bus voltage, read-only, reset zero.
// - Power product of current and right-aligned bus count divides by 5000.
// - Current word is shunt code times calibration, read-only, reset zero.
// - Current product of shunt code and calibration divides by 4096.
// - Current is a signed two's-complement 16-bit word, bit 15 sign.
// - Calibration bits 15..1 writable; bit 0 always reads zero.
// - Calibration resets to zero, so current and power stay zero.
module pmr_top
  import pmr_pkg::*;
#(
  parameter int SHUNT_W = 17,  // width of the signed raw shunt reading
  parameter int BUS_W   = 14   // width of the unsigned raw bus reading
)(
  input  wire logic               mclk,                   // system clock, 10 MHz
  input  wire logic               rst,                    // async reset, active high
  input  wire pmr_reg_req_t       reg_req,                // register access from serial engine
  output logic [15:0]             reg_rdata,              // read data, one cycle after rd
  input  wire logic               mode_wr,                // pulse: host wrote operating mode
  input  wire logic [2:0]         mode_val,               // mode value written
  input  wire logic [1:0]         shunt_gain_setting,     // 0=/1 1=/2 2=/4 3=/8
  input  wire logic               bus_range_select,       // 1 = 32 V, 0 = 16 V
  input  wire logic               conv_toggle,            // converter domain: toggles per cycle
  input  wire logic [SHUNT_W-1:0] shunt_raw,              // raw shunt code, 10 uV per count
  input  wire logic [BUS_W-1:0]   bus_raw,                // raw bus code, 4 mV per count
  output logic                    conversion_ready_flag,  // ready flag level
  output logic                    math_overflow_flag,     // overflow flag level
  output logic                    conv_busy               // arithmetic in progress
);

  // ========================================================================
  // parameter checks
  initial begin
    if (SHUNT_W < 17 || SHUNT_W > 24)
      $error("SHUNT_W must lie in 17..24");
    if (BUS_W < 13 || BUS_W > 16)
      $error("BUS_W must lie in 13..16");
  end

  // ========================================================================
  // helper functions
  function automatic logic [15:0] pmr_clip_shunt(input logic [SHUNT_W-1:0] raw,
                                                 input logic [1:0] gain);
    logic signed [SHUNT_W-1:0] fs;
    logic signed [SHUNT_W-1:0] v;
    fs = $signed(SHUNT_W'(`PMR_SHUNT_FS_G1 << gain));
    v  = $signed(raw);
    if (v > fs)
      pmr_clip_shunt = fs[15:0];
    else if (v < -fs)
      pmr_clip_shunt = 16'((-fs));
    else
      pmr_clip_shunt = v[15:0];
  endfunction

  function automatic logic [12:0] pmr_clip_bus(input logic [BUS_W-1:0] raw,
                                               input logic rng);
    logic [BUS_W-1:0] fs;
    fs = rng ? BUS_W'(`PMR_BUS_FS_32V) : BUS_W'(`PMR_BUS_FS_16V);
    pmr_clip_bus = (raw > fs) ? fs[12:0] : raw[12:0];
  endfunction

  function automatic logic hit(input pmr_reg_req_t r, input logic [7:0] a);
    hit = (r.addr == a);
  endfunction

  // ========================================================================
  // converter event synchroniser: three flops, change once stages 2 and 3 agree
  logic conv_meta_r;
  logic conv_s2_r;
  logic conv_s3_r;
  logic conv_lvl_r;
  logic conv_evt;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      conv_meta_r <= 1'b0;
      conv_s2_r   <= 1'b0;
      conv_s3_r   <= 1'b0;
      conv_lvl_r  <= 1'b0;
    end else begin
      conv_meta_r <= conv_toggle;
      conv_s2_r   <= conv_meta_r;
      conv_s3_r   <= conv_s2_r;
      if (conv_s2_r == conv_s3_r)
        conv_lvl_r <= conv_s3_r;
    end
  end

  assign conv_evt = (conv_s2_r == conv_s3_r) && (conv_s3_r != conv_lvl_r);

  // ========================================================================
  // sequencer: capture, run arithmetic, commit; an event while busy is dropped
  pmr_state_t  state_r;
  pmr_state_t  state_nxt;
  logic        start;
  logic        math_done;
  pmr_math_t   math_res;
  logic [15:0] shunt_cap_r;
  logic [12:0] bus_cap_r;
  logic [15:0] cal_cap_r;
  logic [15:0] cal_r;

  assign start = (state_r == PMR_IDLE) && conv_evt;

  always_comb begin
    state_nxt = state_r;
    case (state_r)
      PMR_IDLE: state_nxt = conv_evt ? PMR_CALC : PMR_IDLE;
      PMR_CALC: state_nxt = math_done ? PMR_IDLE : PMR_CALC;
      default:  state_nxt = PMR_IDLE;
    endcase
  end

  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      state_r <= PMR_IDLE;
    else
      state_r <= state_nxt;
  end

  // the raw words are held steady by the converter around its toggle
  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      shunt_cap_r <= `PMR_RESULT_RST;
      bus_cap_r   <= 13'h0000;
      cal_cap_r   <= `PMR_CALIB_RST;
    end else if (start) begin
      shunt_cap_r <= pmr_clip_shunt(shunt_raw, shunt_gain_setting);
      bus_cap_r   <= pmr_clip_bus(bus_raw, bus_range_select);
      cal_cap_r   <= cal_r;
    end
  end

  pmr_math u_math (
    .mclk    (mclk),
    .rst     (rst),
    .start   (start),
    .shunt   (pmr_clip_shunt(shunt_raw, shunt_gain_setting)),
    .cal     (cal_r),
    .bus_cnt (pmr_clip_bus(bus_raw, bus_range_select)),
    .done    (math_done),
    .res     (math_res)
  );

  // ========================================================================
  // result words, all committed in one cycle
  logic [15:0] shunt_r;
  logic [12:0] bus_mag_r;
  logic [15:0] current_r;
  logic [15:0] power_r;
  logic        ovf_r;
  logic        conversion_ready_flag_r;
  logic        commit;
  logic        pwr_rd;
  logic        mode_clr;

  assign commit = (state_r == PMR_CALC) && math_done;

  always_ff @(posedge mclk or posedge rst) begin
    if (rst) begin
      shunt_r   <= `PMR_RESULT_RST;
      bus_mag_r <= 13'h0000;
      current_r <= `PMR_RESULT_RST;
      power_r   <= `PMR_RESULT_RST;
      ovf_r     <= 1'b0;
    end else if (commit) begin
      shunt_r   <= shunt_cap_r;
      bus_mag_r <= bus_cap_r;
      current_r <= math_res.current;
      power_r   <= math_res.power;
      ovf_r     <= math_res.ovf;
    end
  end

  // ready flag: a commit in the same cycle as a clear wins
  assign pwr_rd   = reg_req.rd && hit(reg_req, `PMR_ADDR_POWER);
  assign mode_clr = mode_wr && (mode_val != `PMR_MODE_PDOWN) && (mode_val != `PMR_MODE_DISABLE);

  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      conversion_ready_flag_r <= 1'b0;
    else if (commit)
      conversion_ready_flag_r <= 1'b1;
    else if (pwr_rd || mode_clr)
      conversion_ready_flag_r <= 1'b0;
  end

  // ========================================================================
  // calibration word: bit 0 is void and never stores a one
  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      cal_r <= `PMR_CALIB_RST;
    else if (reg_req.wr && hit(reg_req, `PMR_ADDR_CALIB))
      cal_r <= {reg_req.wdata[15:1], 1'b0};
  end

  // ========================================================================
  // read port: registered data, unmapped addresses read zero
  logic [15:0] bus_word;

  assign bus_word = {bus_mag_r, 1'b0, conversion_ready_flag_r, ovf_r};

  always_ff @(posedge mclk or posedge rst) begin
    if (rst)
      reg_rdata <= 16'h0000;
    else if (reg_req.rd) begin
      case (reg_req.addr)
        `PMR_ADDR_SHUNT:   reg_rdata <= shunt_r;
        `PMR_ADDR_BUS:     reg_rdata <= bus_word;
        `PMR_ADDR_POWER:   reg_rdata <= power_r;
        `PMR_ADDR_CURRENT: reg_rdata <= current_r;
        `PMR_ADDR_CALIB:   reg_rdata <= cal_r;
        default:           reg_rdata <= 16'h0000;
      endcase
    end
  end

  assign conversion_ready_flag = conversion_ready_flag_r;
  assign math_overflow_flag    = ovf_r;
  assign conv_busy             = (state_r == PMR_CALC);

  // ========================================================================
  // checks
  default clocking cb @(posedge mclk); endclocking
  default disable iff (rst);

  cal_void_a: assert property (cal_r[0] == 1'b0)
    else $error("calibration bit 0 is not zero");

  bus_top_a: assert property (commit && !$past(bus_range_select, 2) && $past(start, 2)
    |=> bus_word[15] == 1'b0)
    else $error("bus bit 15 set in 16 V range");

  bus_fs_a: assert property (bus_mag_r <= `PMR_BUS_FS_32V)
    else $error("bus magnitude above 32 V full scale");

  conversion_ready_flag_set_a: assert property (commit |=> conversion_ready_flag_r && bus_mag_r == $past(bus_cap_r)
    && power_r == $past(math_res.power))
    else $error("ready flag or results not updated together");

  conversion_ready_flag_early_a: assert property ($rose(conversion_ready_flag_r) |-> $past(commit))
    else $error("ready flag rose without a commit");

  conversion_ready_flag_power_a: assert property (pwr_rd && !commit |=> !conversion_ready_flag_r)
    else $error("power read did not clear ready");

  mode_clr_a: assert property (mode_clr && !commit |=> !conversion_ready_flag_r)
    else $error("mode write did not clear ready");

  mode_keep_a: assert property (conversion_ready_flag_r && mode_wr && !mode_clr && !pwr_rd |=> conversion_ready_flag_r)
    else $error("power-down or disable mode write cleared ready");

  cal_zero_a: assert property (commit && cal_cap_r == 16'h0000
    |=> current_r == 16'h0000 && power_r == 16'h0000)
    else $error("nonzero result with zero calibration");

  shunt_clip_a: assert property (start ##2 commit
    |=> ($signed(shunt_r) <= 16'sh7D00) && ($signed(shunt_r) >= -16'sh7D00))
    else $error("shunt code beyond full scale");

  power_ro_a: assert property (reg_req.wr && !commit |=> $stable(power_r) && $stable(current_r))
    else $error("host write changed a read-only result");

  // ========================================================================
  // busy-window, overflow, hold, read-back and range checks
  busy_len_a: assert property (start |=> conv_busy ##1 conv_busy ##1 !conv_busy)
    else $error("arithmetic busy window has the wrong length");

  ovf_commit_a: assert property (commit |=> ovf_r == $past(math_res.ovf))
    else $error("overflow flag not taken from the arithmetic");

  result_hold_a: assert property (!commit
    |=> $stable(current_r) && $stable(power_r) && $stable(bus_mag_r))
    else $error("result word changed outside a commit");

  conversion_ready_flag_hold_a: assert property (conversion_ready_flag_r && !pwr_rd && !mode_clr |=> conversion_ready_flag_r)
    else $error("ready flag dropped without a clear");

  cal_write_a: assert property (reg_req.wr && hit(reg_req, `PMR_ADDR_CALIB)
    |=> cal_r == {$past(reg_req.wdata[15:1]), 1'b0})
    else $error("calibration write not stored");

  cal_read_a: assert property (reg_req.rd && hit(reg_req, `PMR_ADDR_CALIB)
    |=> reg_rdata == $past(cal_r))
    else $error("calibration read returned the wrong word");

  power_read_a: assert property (reg_req.rd && hit(reg_req, `PMR_ADDR_POWER)
    |=> reg_rdata == $past(power_r))
    else $error("power read returned the wrong word");

  bus16_fs_a: assert property (commit && !$past(bus_range_select, 2)
    |=> bus_mag_r <= `PMR_BUS_FS_16V)
    else $error("bus magnitude above 16 V full scale");

  current_read_a: assert property (reg_req.rd && hit(reg_req, `PMR_ADDR_CURRENT)
    |=> reg_rdata == $past(current_r))
    else $error("current read returned the wrong word");

endmodule
`default_nettype wire

// File: pmr_host_model.sv
`timescale 1ns/1ps
`default_nettype none

// ==========================================================================
// serial host seen from the register port: one word per request
module pmr_host_model
  import pmr_pkg::*;
(
  input  wire logic         mclk,   // system clock
  output var pmr_reg_req_t  req,    // register request
  input  wire logic [15:0]  rdata   // read data
);
  initial req = '0;

  // write one word; released lines go inverse so no stale value survives
  task automatic wr(input logic [7:0] a, input logic [15:0] d);
    @(negedge mclk);
    req <= '{addr: a, rd: 1'b0, wr: 1'b1, wdata: d};
    @(negedge mclk);
    req <= '{addr: ~a, rd: 1'b0, wr: 1'b0, wdata: ~d};
  endtask

  // read one word, taken once the answer has settled
  task automatic rd(input logic [7:0] a, output logic [15:0] d);
    @(negedge mclk);
    req <= '{addr: a, rd: 1'b1, wr: 1'b0, wdata: ~req.wdata};
    @(negedge mclk);
    req <= '{addr: ~a, rd: 1'b0, wr: 1'b0, wdata: ~req.wdata};
    @(negedge mclk);
    d = rdata;
  endtask
endmodule

`default_nettype wire

// File: power_monitor_result_registers_tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module power_monitor_result_registers_tb_top
  import pmr_pkg::*;
;
  logic               mclk = 0;
  logic               rst = 1;
  pmr_reg_req_t       req;
  logic [15:0]        rdata;
  logic               mode_wr = 0;
  logic [2:0]         mode_val = 0;
  logic [1:0]         gain = 0;
  logic               rng = 0;
  logic               tog = 0;
  logic signed [16:0] shunt_raw = 0;
  logic [13:0]        bus_raw = 0;
  logic               ready;
  logic               ovf;
  logic               busy;
  int                 miscompares = 0;
  int                 total_checks = 0;
  int                 cyc = 0;
  int                 seed = 90630;
  logic [15:0]        d;
  int                 cal = 0;

  always #50 mclk = ~mclk;

  pmr_top #(.SHUNT_W(17), .BUS_W(14)) u_pmr_top (
    .mclk(mclk), .rst(rst), .reg_req(req), .reg_rdata(rdata), .mode_wr(mode_wr),
    .mode_val(mode_val), .shunt_gain_setting(gain), .bus_range_select(rng),
    .conv_toggle(tog), .shunt_raw(shunt_raw), .bus_raw(bus_raw),
    .conversion_ready_flag(ready), .math_overflow_flag(ovf), .conv_busy(busy));

  pmr_host_model u_pmr_host_model (.mclk(mclk), .req(req), .rdata(rdata));

  // ==========================================================================
  // checking and closing
  task automatic chk(input logic [15:0] got, input logic [15:0] exp);
    total_checks++;
    if (got !== exp) begin
      miscompares++;
      $display("BAD t=%0t got %h exp %h", $time, got, exp);
    end
  endtask

  task automatic test_done();
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0) $display("All tests passed");
    else $display("Some tests failed");
    $finish;
  endtask

  // hang guard, far above the under one thousand cycles the tests need
  always @(posedge mclk) begin
    cyc++;
    if (cyc == 8000) begin
      miscompares++;
      test_done();
    end
  end

  // reference arithmetic with wide integers, saturation on overflow
  function automatic void calc(input int sr, input int br, input int g, input int r,
                               output int sh, output int bw, output int cu, output int pw,
                               output int ov);
    longint p;
    int fs;
    fs = 4000 << g;
    sh = sr > fs ? fs : (sr < -fs ? -fs : sr);
    bw = r ? 8000 : 4000;
    if (br < bw) bw = br;
    p = (longint'(sh) * longint'(cal / 2 * 2)) >>> 12;
    ov = (p > 32767 || p < -32768);
    p = p > 32767 ? 32767 : (p < -32768 ? -32768 : p);
    cu = int'(p);
    p = (p < 0 ? -p : p) * bw / 5000;
    if (p > 65535) ov = 1;
    pw = p > 65535 ? 65535 : int'(p);
  endfunction

  // launch one conversion; flags are sampled at falling edges, where they have settled
  task automatic fire(input int sr, input int br, input int g, input int r);
    @(negedge mclk);
    shunt_raw = sr[16:0];
    bus_raw = br[13:0];
    gain = g[1:0];
    rng = r[0];
    tog = ~tog;
    for (int i = 0; i < 40 && busy !== 1'b1; i++) @(negedge mclk);
    chk({15'h0, busy}, 16'h0001);
    for (int i = 0; i < 40 && ready !== 1'b1; i++) @(negedge mclk);
    chk({15'h0, ready}, 16'h0001);
    chk({15'h0, busy}, 16'h0000);
  endtask

  // one conversion, then a poll that reads power fourth and the bus word again last
  task automatic conv(input int sr, input int br, input int g, input int r);
    int sh, bw, cu, pw, ov;
    int exp_q[$];
    calc(sr, br, g, r, sh, bw, cu, pw, ov);
    exp_q.push_back(sh);
    exp_q.push_back(cu);
    fire(sr, br, g, r);
    chk({15'h0, ovf}, ov[15:0]);
    u_pmr_host_model.rd(8'h01, d);
    chk(d, 16'(exp_q.pop_front()));
    u_pmr_host_model.rd(8'h04, d);
    chk(d, 16'(exp_q.pop_front()));
    u_pmr_host_model.rd(8'h02, d);
    chk(d, {bw[12:0], 1'b0, 1'b1, ov[0]});
    u_pmr_host_model.rd(8'h03, d);
    chk(d, pw[15:0]);
    u_pmr_host_model.rd(8'h02, d);
    chk({15'h0, d[1]}, 16'h0000);
  endtask

  // ==========================================================================
  // main sequence
  initial begin
    repeat (10) @(negedge mclk);
    rst = 0;
    // read-only words ignore writes; unmapped places read zero
    for (int a = 1; a < 5; a++) u_pmr_host_model.wr(a[7:0], 16'hFFFF);
    for (int a = 0; a < 8; a++) begin
      u_pmr_host_model.rd(a[7:0], d);
      chk(d, 16'h0000);
    end
    $display("test reset and read-only done");
    u_pmr_host_model.wr(8'h05, 16'hFFFF);
    u_pmr_host_model.rd(8'h05, d);
    chk(d, 16'hFFFE);
    u_pmr_host_model.wr(8'h05, 16'h0000);
    conv(3000, 3000, 0, 0);
    $display("test calibration done");
    // worked example, the two negative overrange codes, then the positive full-scale code
    cal = 16'h5000;
    u_pmr_host_model.wr(8'h05, cal[15:0]);
    conv(2000, 2995, 0, 0);
    conv(-32002, 9000, 3, 1);
    conv(-4002, 9000, 0, 0);
    conv(32000, 8000, 3, 1);
    $display("test boundaries done");
    for (int k = 0; k < 16; k++) begin
      cal = $random(seed) & 16'hFFFF;
      if (k < 8) cal = cal & 16'h0FFF;
      u_pmr_host_model.wr(8'h05, cal[15:0]);
      conv($random(seed) % 40000, $unsigned($random(seed)) % 9000, k % 4, k / 4 % 2);
    end
    $display("test random conversions done");
    // only modes other than power-down and disable drop the ready flag
    for (int m = 0; m < 8; m++) begin
      fire(1000, 1000, 1, 1);
      mode_wr = 1;
      mode_val = m[2:0];
      @(negedge mclk);
      mode_wr = 0;
      chk({15'h0, ready}, {15'h0, (m == 0 || m == 4)});
      u_pmr_host_model.rd(8'h03, d);
    end
    $display("test mode writes done");
    test_done();
  end
endmodule

`default_nettype wire
